// ==== hw/dss_pkg.sv ====
// Shared constants, types and source decoding for the start/stop sequencer
package dss_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CFG   = 8'h00;
	localparam logic [7:0] A_ASGN0 = 8'h04;
	localparam logic [7:0] A_ASGN1 = 8'h08;
	localparam logic [7:0] A_TIME  = 8'h0c;
	localparam logic [7:0] A_LIM   = 8'h10;
	localparam logic [7:0] A_STAT  = 8'h14;
	localparam logic [7:0] A_ISTAT = 8'h18;
	localparam logic [7:0] A_IEN   = 8'h1c;
	localparam logic [7:0] A_ICLR  = 8'h20;
	// Reset values
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] ASGN_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_RST = 32'h0000_0000;
	localparam logic [31:0] LIM_RST  = 32'hffff_ffff;
	// Input function code that carries the search enable
	localparam logic [7:0] FN_SEARCH_EN = 8'h1a;
	// Timing: one tick is 0.1 s, delays are counted in ticks
	localparam int CLK_MHZ       = 125;
	localparam int TICK_MS       = 100;
	localparam int TICK_CYC      = TICK_MS * 1000 * CLK_MHZ;
	localparam int SEARCH_MAX_MS = 1200;
	localparam logic [3:0] SEARCH_TICKS = 4'(SEARCH_MAX_MS / TICK_MS);
	// Event bit positions
	localparam int EV_FOUND   = 0;
	localparam int EV_ABANDON = 1;
	localparam int EV_OCTRIP  = 2;
	localparam int EV_FASTLIM = 3;
	localparam int EV_STOP    = 4;
	localparam int EV_N       = 5;

	typedef enum logic [1:0] {SRC_LOCAL, SRC_STD, SRC_OPT, SRC_FB} dss_src_e;
	typedef enum {ST_IDLE, ST_WAIT, ST_SEARCH, ST_RUN, ST_DECEL} dss_state_e;

	typedef struct packed {
		logic [9:0] rsv_h;
		logic [1:0] fieldbus_source_setting;
		logic [3:0] link_source_setting;
		logic [4:0] rsv_m;
		logic       run_source_setting;
		logic       fast_limit_setting;
		logic       stop_mode_setting;
		logic       rsv_b;
		logic [2:0] dip_restart_mode;
		logic [1:0] rsv_l;
		logic [1:0] search_mode_setting;
	} dss_cfg_s;

	typedef struct packed {
		logic [8:0] rsv_h;
		logic [6:0] restart_wait_time;
		logic [8:0] rsv_l;
		logic [6:0] search_delay_setting;
	} dss_time_s;

	// Frequency source from the link source setting
	function automatic dss_src_e freq_src_of(input logic [3:0] l);
		unique case (l)
			4'h1, 4'h3, 4'h7: freq_src_of = SRC_STD;
			4'h4, 4'h5, 4'h8: freq_src_of = SRC_OPT;
			default:          freq_src_of = SRC_LOCAL;
		endcase
	endfunction : freq_src_of

	// Run source from the link source setting
	function automatic dss_src_e run_src_of(input logic [3:0] l);
		unique case (l)
			4'h2, 4'h3, 4'h5: run_src_of = SRC_STD;
			4'h6, 4'h7, 4'h8: run_src_of = SRC_OPT;
			default:          run_src_of = SRC_LOCAL;
		endcase
	endfunction : run_src_of

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
		end
	endfunction : merge
endpackage : dss_pkg

// ==== hw/dss_top.sv ====
// Motor drive start/stop sequencer with source select and AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Search enable is live only from an input assigned function 26, else it reads off.
// - Search runs at most 1.2 s, then the drive ramps to the reference.
// - Search mode 0 never searches, 1 only on dip restart, 2 always; the enable input means always.
// - Dip-restart search needs dip restart mode 4 or 5.
// - A start by run turning on waits the search delay (0.0 to 12.7 s) before searching.
// - Dip, coast-release and auto-reset restarts wait the restart wait time first.
// - A found speed above maximum or upper limit is dropped and the start is normal.
// - With search mode 1, dip mode 4 or 5 and an outage time set, run turning on still searches.
// - An overcurrent or overvoltage trip during search restarts the search.
// - Run off decelerates for stop mode 0 and cuts the output for stop mode 1.
// - A lowered reference always decelerates, whatever the stop mode.
// - Fast overcurrent trips for fast limit 0 and blanks gates for fast limit 1.
// - The link source setting 0 to 8 picks frequency and run sources.
// - Local frequency is setting or multistep; local run is keypad or inputs.
// - The field-bus source setting 1, 2, 3 overrides frequency, run or both.
module dss_top #(
	parameter int TICK_CYC = dss_pkg::TICK_CYC,
	parameter int FW       = 16
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// Command sources
	input  wire logic [FW-1:0] freq_setting,
	input  wire logic [FW-1:0] freq_multistep,
	input  wire logic          multistep_sel,
	input  wire logic          run_keypad,
	input  wire logic          run_terminal,
	input  wire logic [FW-1:0] freq_std,
	input  wire logic          run_std,
	input  wire logic [FW-1:0] freq_opt,
	input  wire logic          run_opt,
	input  wire logic [FW-1:0] freq_fb,
	input  wire logic          run_fb,
	// Terminals and power stage
	input  wire logic [4:0]    dig_in,
	input  wire logic          coast_input,
	input  wire logic          dip_restart,
	input  wire logic          auto_reset,
	input  wire logic          trip_oc,
	input  wire logic          trip_ov,
	input  wire logic          fast_over,
	input  wire logic          speed_found,
	input  wire logic [FW-1:0] speed_est,
	input  wire logic          at_zero,
	// Drive outputs
	output logic               gate_en,
	output logic               search_active,
	output logic               decel_active,
	output logic [FW-1:0]      freq_ref,
	output logic [FW-1:0]      start_freq,
	output logic               gate_block,
	output logic               oc_trip,
	output logic               irq
);
	dss_pkg::dss_cfg_s   cfg;
	dss_pkg::dss_time_s  tim;
	dss_pkg::dss_state_e state;
	dss_pkg::dss_src_e   fsrc, rsrc;
	logic [31:0] asgn0, asgn1, lim;
	logic [dss_pkg::EV_N-1:0] istat, ien, ev;
	logic aw_held, w_held;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] s_q;
	logic [31:0] tick_cnt;
	logic tick, phase_start;
	logic [6:0] wait_cnt, delay_q;
	logic [3:0] srch_cnt;
	logic want_search, run_q, coast_q;
	logic [4:0] srch_en_hit;
	logic srch_en, run_now, fsel_lower, dip45, srch_norm, srch_run, abort_now, over_lim;
	logic [FW-1:0] fsel;

	// Search enable from any input assigned the search function
	for (genvar i = 0; i < 5; i++) begin : g_srch_en
		assign srch_en_hit[i] = (i < 4 ? asgn0[8*(i%4) +: 8] : asgn1[7:0]) == dss_pkg::FN_SEARCH_EN;
	end
	assign srch_en = |(srch_en_hit & dig_in);

	// Source selection, field bus overriding the link setting
	always_comb begin
		fsrc = dss_pkg::freq_src_of(cfg.link_source_setting);
		rsrc = dss_pkg::run_src_of(cfg.link_source_setting);
		if (cfg.fieldbus_source_setting[0]) fsrc = dss_pkg::SRC_FB;
		if (cfg.fieldbus_source_setting[1]) rsrc = dss_pkg::SRC_FB;
		unique case (fsrc)
			dss_pkg::SRC_LOCAL: fsel = multistep_sel ? freq_multistep : freq_setting;
			dss_pkg::SRC_STD:   fsel = freq_std;
			dss_pkg::SRC_OPT:   fsel = freq_opt;
			dss_pkg::SRC_FB:    fsel = freq_fb;
		endcase
		unique case (rsrc)
			dss_pkg::SRC_LOCAL: run_now = cfg.run_source_setting ? run_terminal : run_keypad;
			dss_pkg::SRC_STD:   run_now = run_std;
			dss_pkg::SRC_OPT:   run_now = run_opt;
			dss_pkg::SRC_FB:    run_now = run_fb;
		endcase
	end

	// Start qualifiers
	assign dip45     = cfg.dip_restart_mode == 3'h4 || cfg.dip_restart_mode == 3'h5;
	assign srch_norm = srch_en || cfg.search_mode_setting == 2'h2;
	assign srch_run  = srch_norm || (cfg.search_mode_setting == 2'h1 && dip45 && asgn1[15:8] != 8'h00);
	assign abort_now = coast_input || (fast_over && !cfg.fast_limit_setting);
	assign over_lim  = speed_est > lim[FW-1:0] || speed_est > lim[16 +: FW];
	assign fsel_lower = fsel < freq_ref;

	// 0.1 s tick, realigned whenever a timed phase begins
	always_ff @(posedge aclk) begin
		if (!aresetn || phase_start || tick) tick_cnt <= 32'h0000_0000;
		else tick_cnt <= tick_cnt + 32'h0000_0001;
	end
	assign tick = tick_cnt == 32'(TICK_CYC - 1);

	// Edge history of run and coast
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q   <= 1'b0;
			coast_q <= 1'b0;
		end else begin
			run_q   <= run_now;
			coast_q <= coast_input;
		end
	end

	// Sequencer; a timed phase is entered with its tick counter cleared
	always_comb begin
		phase_start = 1'b0;
		if (state == dss_pkg::ST_IDLE) phase_start = 1'b1;
		if (state == dss_pkg::ST_WAIT && wait_cnt >= delay_q) phase_start = 1'b1;
		if (state == dss_pkg::ST_SEARCH && (trip_oc || trip_ov)) phase_start = 1'b1;
	end

	always_ff @(posedge aclk) begin
		ev[dss_pkg::EV_FOUND]   <= 1'b0;
		ev[dss_pkg::EV_ABANDON] <= 1'b0;
		ev[dss_pkg::EV_STOP]    <= 1'b0;
		ev[dss_pkg::EV_OCTRIP]  <= aresetn && fast_over && !cfg.fast_limit_setting; // Same timing as oc_trip
		ev[dss_pkg::EV_FASTLIM] <= aresetn && fast_over && cfg.fast_limit_setting;
		if (!aresetn) begin
			state       <= dss_pkg::ST_IDLE;
			wait_cnt    <= 7'h00;
			delay_q     <= 7'h00;
			srch_cnt    <= 4'h0;
			want_search <= 1'b0;
			start_freq  <= '0;
		end else if (abort_now) begin
			state <= dss_pkg::ST_IDLE; // Coast input or trip: output off at once
		end else begin
			unique case (state)
				dss_pkg::ST_IDLE: begin
					wait_cnt <= 7'h00;
					srch_cnt <= 4'h0;
					if (run_now && !run_q) begin
						want_search <= srch_run;
						delay_q     <= srch_run ? tim.search_delay_setting : 7'h00;
						state       <= dss_pkg::ST_WAIT;
					end else if (run_now && ((dip_restart && dip45) || (coast_q && !coast_input) || auto_reset)) begin
						want_search <= (dip_restart && dip45) ? (srch_norm || cfg.search_mode_setting == 2'h1)
							: srch_norm;
						delay_q     <= tim.restart_wait_time;
						state       <= dss_pkg::ST_WAIT;
					end
				end
				dss_pkg::ST_WAIT: begin
					if (!run_now) state <= dss_pkg::ST_IDLE;
					else if (wait_cnt >= delay_q) begin
						start_freq <= '0;
						state      <= want_search ? dss_pkg::ST_SEARCH : dss_pkg::ST_RUN;
					end else if (tick) wait_cnt <= wait_cnt + 7'h01;
				end
				dss_pkg::ST_SEARCH: begin
					if (!run_now) state <= dss_pkg::ST_IDLE;
					else if (trip_oc || trip_ov) srch_cnt <= 4'h0;
					else if (speed_found) begin
						start_freq <= over_lim ? '0 : speed_est;
						ev[dss_pkg::EV_FOUND]   <= !over_lim;
						ev[dss_pkg::EV_ABANDON] <= over_lim;
						state <= dss_pkg::ST_RUN;
					end else if (srch_cnt == dss_pkg::SEARCH_TICKS) begin
						ev[dss_pkg::EV_ABANDON] <= 1'b1;
						state <= dss_pkg::ST_RUN;
					end else if (tick) srch_cnt <= srch_cnt + 4'h1;
				end
				dss_pkg::ST_RUN: begin
					if (trip_oc || trip_ov) state <= dss_pkg::ST_IDLE;
					else if (!run_now) begin
						state <= cfg.stop_mode_setting ? dss_pkg::ST_IDLE : dss_pkg::ST_DECEL;
						ev[dss_pkg::EV_STOP] <= cfg.stop_mode_setting;
					end
				end
				dss_pkg::ST_DECEL: begin
					if (run_now) state <= dss_pkg::ST_RUN;
					else if (at_zero || trip_oc || trip_ov) begin
						state <= dss_pkg::ST_IDLE;
						ev[dss_pkg::EV_STOP] <= 1'b1;
					end
				end
			endcase
		end
	end

	// Ramp target and direction; a lowered reference always ramps down
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_ref      <= '0;
			decel_active  <= 1'b0;
			search_active <= 1'b0;
		end else begin
			freq_ref      <= (state == dss_pkg::ST_RUN) ? fsel : '0;
			decel_active  <= state == dss_pkg::ST_DECEL || (state == dss_pkg::ST_RUN && fsel_lower);
			search_active <= state == dss_pkg::ST_SEARCH;
		end
	end

	// Fast current limit: blank gates or trip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_block <= 1'b0;
			oc_trip    <= 1'b0;
		end else begin
			gate_block <= fast_over && cfg.fast_limit_setting;
			oc_trip    <= fast_over && !cfg.fast_limit_setting;
		end
	end
	// Gates held off while blanked; the sequencer keeps its state
	assign gate_en = (state == dss_pkg::ST_SEARCH || state == dss_pkg::ST_RUN || state == dss_pkg::ST_DECEL)
		&& !gate_block;

	// AXI4-Lite write path: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_q    <= 8'h00;
			w_q     <= 32'h0000_0000;
			s_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_q    <= s_axi_wdata;
				s_q    <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_q[7:2] <= dss_pkg::A_ICLR[7:2]) ? 2'h0 : 2'h2; // Offsets above 0x23 get SLVERR
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg   <= dss_pkg::CFG_RST;
			asgn0 <= dss_pkg::ASGN_RST;
			asgn1 <= dss_pkg::ASGN_RST;
			tim   <= dss_pkg::TIME_RST;
			lim   <= dss_pkg::LIM_RST;
			ien   <= '0;
		end else if (aw_held && w_held) begin
			unique case (aw_q)
				dss_pkg::A_CFG:   cfg   <= dss_pkg::merge(cfg, w_q, s_q);
				dss_pkg::A_ASGN0: asgn0 <= dss_pkg::merge(asgn0, w_q, s_q);
				dss_pkg::A_ASGN1: asgn1 <= dss_pkg::merge(asgn1, w_q, s_q);
				dss_pkg::A_TIME:  tim   <= dss_pkg::merge(tim, w_q, s_q);
				dss_pkg::A_LIM:   lim   <= dss_pkg::merge(lim, w_q, s_q);
				dss_pkg::A_IEN:   ien   <= w_q[dss_pkg::EV_N-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) istat <= '0;
		else if (aw_held && w_held && aw_q == dss_pkg::A_ICLR) istat <= (istat & ~w_q[dss_pkg::EV_N-1:0]) | ev;
		else istat <= istat | ev;
	end
	assign irq = |(istat & ien);

	// AXI4-Lite read path, one cycle to rvalid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			unique case (s_axi_araddr)
				dss_pkg::A_CFG:   s_axi_rdata <= cfg;
				dss_pkg::A_ASGN0: s_axi_rdata <= asgn0;
				dss_pkg::A_ASGN1: s_axi_rdata <= asgn1;
				dss_pkg::A_TIME:  s_axi_rdata <= tim;
				dss_pkg::A_LIM:   s_axi_rdata <= lim;
				dss_pkg::A_STAT:  s_axi_rdata <= {20'h00000, rsrc, fsrc, 1'b0, srch_en, gate_en, oc_trip, 1'b0,
					3'(state)};
				dss_pkg::A_ISTAT: s_axi_rdata <= 32'(istat);
				dss_pkg::A_IEN:   s_axi_rdata <= 32'(ien);
				dss_pkg::A_ICLR:  s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end

	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_enable_unset: assert property (srch_en_hit == 5'h00 |-> !srch_en) else $error("enable without assignment");
	chk_search_bound: assert property (state == dss_pkg::ST_SEARCH |-> srch_cnt <= dss_pkg::SEARCH_TICKS)
		else $error("search overran");
	chk_mode_zero: assert property (state == dss_pkg::ST_IDLE && run_now && !run_q && !abort_now
		&& cfg.search_mode_setting == 2'h0 && !srch_en |=> !want_search) else $error("mode 0 searched");
	chk_dip_mode: assert property (state == dss_pkg::ST_IDLE && !abort_now && !dip45 && !(run_now && !run_q)
		&& !(coast_q && !coast_input) && !auto_reset |=> state == dss_pkg::ST_IDLE)
		else $error("dip restart without mode 4 or 5");
	chk_wait_hold: assert property (state == dss_pkg::ST_WAIT && wait_cnt < delay_q
		|=> state inside {dss_pkg::ST_WAIT, dss_pkg::ST_IDLE}) else $error("started before delay");
	chk_found_limit: assert property (state == dss_pkg::ST_SEARCH && speed_found && over_lim && run_now
		&& !abort_now && !trip_oc && !trip_ov |=> state == dss_pkg::ST_RUN && start_freq == '0)
		else $error("over-limit speed kept");
	chk_outage_search: assert property (state == dss_pkg::ST_IDLE && run_now && !run_q && !abort_now && dip45
		&& cfg.search_mode_setting == 2'h1 && asgn1[15:8] != 8'h00 |=> want_search)
		else $error("outage case skipped search");
	chk_trip_restart: assert property (state == dss_pkg::ST_SEARCH && run_now && !abort_now && trip_ov
		|=> state == dss_pkg::ST_SEARCH && srch_cnt == 4'h0) else $error("search not restarted");
	chk_coast_stop: assert property (state == dss_pkg::ST_RUN && !run_now && !abort_now && !trip_oc && !trip_ov
		&& cfg.stop_mode_setting |=> !gate_en) else $error("coast stop left gates on");
	chk_fast_limit: assert property (fast_over && cfg.fast_limit_setting |=> gate_block && !gate_en && !oc_trip)
		else $error("fast limit mishandled");
	chk_fb_both: assert property (cfg.fieldbus_source_setting == 2'h3 |-> fsrc == dss_pkg::SRC_FB
		&& rsrc == dss_pkg::SRC_FB) else $error("field bus override lost");
	cov_search_found: cover property (state == dss_pkg::ST_SEARCH ##1 ev[dss_pkg::EV_FOUND]);
	cov_decel_stop: cover property (state == dss_pkg::ST_DECEL ##1 state == dss_pkg::ST_IDLE);
	cov_irq: cover property ($rose(irq));
endmodule : dss_top
`default_nettype wire

// ==== sim/dss_motor_model.sv ====
// Behavioural motor and power stage answering speed search and ramp-down
`timescale 1ns/10ps
`default_nettype none
module dss_motor_model (
	// Clock
	input  wire logic        aclk,
	// Drive state
	input  wire logic        search_active,
	input  wire logic        decel_active,
	// Bench knobs
	input  wire logic [7:0]  found_dly,
	input  wire logic [15:0] speed,
	// Answers
	output logic             speed_found,
	output logic [15:0]      speed_est,
	output logic             at_zero
);
	logic [7:0] s_cnt;
	logic [7:0] d_cnt;
	// Speed answer after a settable wait; zero never answers, to reach the timeout
	always_ff @(posedge aclk) begin
		s_cnt       <= search_active ? s_cnt + 8'h01 : 8'h00;
		speed_found <= search_active && found_dly != 8'h00 && s_cnt == found_dly;
		// Estimate is only valid with the pulse, so it churns otherwise
		speed_est   <= (s_cnt == found_dly) ? speed : {8'ha5, s_cnt} ^ {16{s_cnt[0]}};
	end
	// Ramp reaches zero some cycles into a stop
	always_ff @(posedge aclk) begin
		d_cnt   <= decel_active ? d_cnt + 8'h01 : 8'h00;
		at_zero <= d_cnt >= 8'h08;
	end
endmodule : dss_motor_model
`default_nettype wire

// ==== sim/dss_top_tb.sv ====
// Self-checking bench for the start/stop sequencer
`timescale 1ns/10ps
`default_nettype none
module dss_top_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, found_dly;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] freq_setting, freq_multistep, freq_std, freq_opt, freq_fb, speed_est, freq_ref, start_freq, speed;
	logic        multistep_sel, run_keypad, run_terminal, run_std, run_opt, run_fb, coast_input, dip_restart;
	logic        auto_reset, trip_oc, trip_ov, fast_over, speed_found, at_zero, gate_en, search_active;
	logic        decel_active, gate_block, oc_trip, irq;
	logic [4:0]  dig_in;
	int          n_errors = 0;
	int          comparisons = 0;
	int          n;

	// Short tick keeps the run brief
	dss_top #(.TICK_CYC(10)) dss_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.freq_setting, .freq_multistep, .multistep_sel, .run_keypad, .run_terminal, .freq_std, .run_std,
		.freq_opt, .run_opt, .freq_fb, .run_fb, .dig_in, .coast_input, .dip_restart, .auto_reset, .trip_oc,
		.trip_ov, .fast_over, .speed_found, .speed_est, .at_zero, .gate_en, .search_active, .decel_active,
		.freq_ref, .start_freq, .gate_block, .oc_trip, .irq);
	dss_motor_model dss_motor_model_i (.aclk, .search_active, .decel_active, .found_dly, .speed,
		.speed_found, .speed_est, .at_zero);

	// Clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Write with address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic t_regs;
		axi_rd(dss_pkg::A_LIM);
		chk("lim reset", rd, dss_pkg::LIM_RST);
		axi_rd(dss_pkg::A_CFG);
		chk("cfg reset", rd, dss_pkg::CFG_RST);
		axi_wr(dss_pkg::A_ICLR, 32'h0000_001f);
		axi_rd(dss_pkg::A_ICLR);
		chk("clear reads zero", rd, 32'h0000_0000);
		axi_rd(8'h24);
		chk("unmapped read", {rd[29:0], rsp}, 32'h0000_0002);
		axi_wr(8'h24, 32'h0000_0001);
		chk("unmapped write", 32'(rsp), 32'h0000_0002);
	endtask : t_regs

	// Every link value, then each field-bus override
	task automatic t_src;
		logic [1:0] fs;
		logic [1:0] rs;
		for (int l = 0; l < 12; l++) begin
			fs = (l == 1 || l == 3 || l == 7) ? 2'h1 : (l == 4 || l == 5 || l == 8) ? 2'h2 : 2'h0;
			rs = (l == 2 || l == 3 || l == 5) ? 2'h1 : (l == 6 || l == 7 || l == 8) ? 2'h2 : 2'h0;
			if (l > 8) fs = ((l - 8) & 1) != 0 ? 2'h3 : 2'h0;
			if (l > 8) rs = ((l - 8) & 2) != 0 ? 2'h3 : 2'h0;
			axi_wr(dss_pkg::A_CFG, l < 9 ? 32'(l) << 16 : 32'(l - 8) << 20);
			axi_rd(dss_pkg::A_STAT);
			chk("freq source", 32'(rd[9:8]), 32'(fs));
			chk("run source", 32'(rd[11:10]), 32'(rs));
		end
	endtask : t_src

	// Delayed search, found speed, lowered reference, coast stop
	task automatic t_search;
		axi_wr(dss_pkg::A_TIME, 32'h0000_0003);
		axi_wr(dss_pkg::A_CFG, 32'h0000_0102);
		axi_wr(dss_pkg::A_IEN, 32'h0000_0001);
		@(posedge aclk);
		found_dly    <= 8'h05;
		speed        <= 16'h0100;
		freq_setting <= 16'h0200;
		run_keypad   <= 1'b1;
		repeat (25) @(posedge aclk);
		chk("search held by delay", 32'(search_active), 32'h0);
		for (n = 0; n < 30 && !search_active; n++) @(posedge aclk);
		chk("search after delay", 32'(search_active), 32'h1);
		for (n = 0; n < 130 && search_active; n++) @(posedge aclk);
		#1;
		chk("start from found speed", 32'(start_freq), 32'h0000_0100);
		chk("gates on", 32'(gate_en), 32'h1);
		chk("found raises irq", 32'(irq), 32'h1);
		axi_wr(dss_pkg::A_ICLR, 32'h0000_0001);
		chk("irq cleared", 32'(irq), 32'h0);
		freq_setting <= 16'h0080;
		@(posedge aclk);
		#1;
		chk("lowered ref decelerates", 32'(decel_active), 32'h1);
		@(posedge aclk);
		run_keypad <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		chk("coast cuts output", 32'({gate_en, decel_active}), 32'h0);
	endtask : t_search

	// No search, fast limit both ways, ramped stop
	task automatic t_stop;
		axi_wr(dss_pkg::A_CFG, 32'h0003_0200);
		@(posedge aclk);
		freq_std <= 16'h0300;
		run_std  <= 1'b1;
		repeat (4) @(posedge aclk);
		#1;
		chk("no search in mode 0", 32'(search_active), 32'h0);
		chk("freq from standard link", 32'(freq_ref), 32'h0000_0300);
		@(posedge aclk);
		fast_over <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		chk("fast limit blanks", 32'({gate_block, oc_trip, gate_en}), 32'h4);
		@(posedge aclk);
		fast_over <= 1'b0;
		run_std   <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
		chk("ramp down on stop", 32'({decel_active, gate_en}), 32'h3);
		for (n = 0; n < 40 && gate_en; n++) @(posedge aclk);
		#1;
		chk("stopped at zero", 32'(gate_en), 32'h0);
		axi_wr(dss_pkg::A_CFG, 32'h0003_0000);
		run_std <= 1'b1;
		repeat (4) @(posedge aclk);
		fast_over <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		chk("fast over trips", 32'({oc_trip, gate_en}), 32'h2);
		@(posedge aclk);
		fast_over <= 1'b0;
		run_std   <= 1'b0;
	endtask : t_stop

	// Search enabled by an assigned input, result above the maximum
	task automatic t_abandon;
		axi_wr(dss_pkg::A_LIM, 32'hffff_0080);
		axi_wr(dss_pkg::A_ASGN0, 32'h0000_001a);
		axi_wr(dss_pkg::A_TIME, 32'h0000_0000);
		axi_wr(dss_pkg::A_CFG, 32'h0000_0000);
		dig_in     <= 5'h01;
		run_keypad <= 1'b1;
		for (n = 0; n < 10 && !search_active; n++) @(posedge aclk);
		chk("input enables search", 32'(search_active), 32'h1);
		for (n = 0; n < 130 && search_active; n++) @(posedge aclk);
		#1;
		chk("fast speed dropped", 32'(start_freq), 32'h0000_0000);
		chk("normal start", 32'(gate_en), 32'h1);
		axi_rd(dss_pkg::A_ISTAT);
		chk("abandon flagged", 32'(rd[1]), 32'h1);
		run_keypad <= 1'b0;
		dig_in     <= 5'h00;
	endtask : t_abandon

	// Coast restart, trip in search, timeout
	task automatic t_coast;
		axi_wr(dss_pkg::A_TIME, 32'h0002_0000);
		axi_wr(dss_pkg::A_CFG, 32'h0000_0442);
		found_dly      <= 8'h00;
		freq_multistep <= 16'h0050;
		multistep_sel  <= 1'b1;
		run_terminal   <= 1'b1;
		coast_input    <= 1'b1;
		repeat (3) @(posedge aclk);
		coast_input <= 1'b0;
		repeat (15) @(posedge aclk);
		chk("restart wait", 32'(search_active), 32'h0);
		for (n = 0; n < 40 && !search_active; n++) @(posedge aclk);
		chk("search after wait", 32'(search_active), 32'h1);
		repeat (50) @(posedge aclk);
		trip_ov <= 1'b1;
		@(posedge aclk);
		trip_ov <= 1'b0;
		repeat (90) @(posedge aclk);
		chk("trip restarts search", 32'(search_active), 32'h1);
		for (n = 0; n < 60 && search_active; n++) @(posedge aclk);
		#1;
		chk("timeout runs", 32'({gate_en, search_active}), 32'h2);
		chk("multistep freq", 32'(freq_ref), 32'h0000_0050);
	endtask : t_coast

	// Dip restart, outage search
	task automatic t_dip;
		axi_wr(dss_pkg::A_ASGN1, 32'h0000_0100);
		axi_wr(dss_pkg::A_CFG, 32'h0000_0441);
		trip_oc <= 1'b1;
		@(posedge aclk);
		trip_oc     <= 1'b0;
		dip_restart <= 1'b1;
		@(posedge aclk);
		dip_restart <= 1'b0;
		for (n = 0; n < 40 && !search_active; n++) @(posedge aclk);
		chk("dip restart searches", 32'(search_active), 32'h1);
		run_terminal <= 1'b0;
		@(posedge aclk);
		run_terminal <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("run on searches", 32'(search_active), 32'h1);
	endtask : t_dip

	task automatic tally_and_finish;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, found_dly, speed} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{freq_setting, freq_multistep, freq_std, freq_opt, freq_fb, dig_in} = '0;
		{multistep_sel, run_keypad, run_terminal, run_std, run_opt, run_fb, coast_input} = '0;
		{dip_restart, auto_reset, trip_oc, trip_ov, fast_over} = '0;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_src();
		t_search();
		t_stop();
		t_abandon();
		t_coast();
		t_dip();
		tally_and_finish();
	end
endmodule : dss_top_tb
`default_nettype wire
